// file: src/epscp_pkg.sv
// ==========================================================================
// shared constants of the serial command port
package epscp_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CNT_W = 4;
  localparam logic [3:0] BITS_4W = 4'h8; // bits per unit, four-wire
  localparam logic [3:0] BITS_3W = 4'h9; // bits per unit, three-wire
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1; // counter step and last-bit offset
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] CMD_DATA_START = 8'h10; // start of display data stream
  localparam logic STRAP_THREE_WIRE = 1'b1; // strap high selects three-wire
  typedef enum logic [1:0] {
    EPSCP_IDLE,
    EPSCP_RAM_STREAM
  } epscp_stream_type;
endpackage

// file: src/epscp_port.sv
`timescale 1ns/1ps
// Overview of operation
// - four-wire link uses clock, data, data/command select and low-active chip select.
// - each data bit is sampled on the rising edge of the serial clock.
// - bits shift into an eight-bit register, bit 7 first and bit 0 last.
// - the byte is handed on at the very edge that completes it.
// - the port is write only and never drives data back.
// - four- or three-wire mode comes from a static strap, not a command.
// - three-wire mode ignores the select line, which may be tied low.
// - a three-wire unit is nine bits, the flag first then bits 7 to 0.
// - in three-wire mode flag one means RAM data and flag zero a command.
// - apart from the flag source, three-wire behaves like four-wire.
// - in four-wire mode select high means data and low means command.
// - data is ignored while chip select is high; the clock still steps the reset and strap flops.
// - busy output is low while the panel, memory or sensor work runs.
// - after the data-start command, data bytes go to RAM until a command.
module epscp_port (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic serial_data_in_i,
  input wire logic dc_sel_i,
  input wire logic cs_n_i,
  input wire logic interface_select_strap_i,
  input wire logic engine_busy_i,
  output logic [7:0] cmd_byte_o,
  output logic cmd_valid_o,
  output logic [7:0] ram_byte_o,
  output logic ram_valid_o,
  output logic ram_stream_o,
  output logic three_wire_mode_o,
  output logic busy_n_o
);
  // ========================================================================
  // link domain: shift register on the host serial clock
  // ========================================================================
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic flag_r;
  logic [7:0] hold_byte_r;
  logic hold_dc_r;
  logic byte_tgl_r;
  logic link_rst_n_r1;
  logic link_rst_n_r2;
  logic strap_l1_r;
  logic strap_l2_r;
  logic mode3_link;
  logic [3:0] unit_len;
  logic is_last;

  // reset reaches the link domain through two flops; the clock may stall
  always_ff @(posedge sclk_i) begin
    link_rst_n_r1 <= resetn_i;
    link_rst_n_r2 <= link_rst_n_r1;
  end

  // strap is a pin: two link flops before anything reads it; a strap change
  // only counts after two link clock edges, so the host moves it while idle
  always_ff @(posedge sclk_i) begin
    strap_l1_r <= interface_select_strap_i;
    strap_l2_r <= strap_l1_r;
  end
  assign mode3_link = (strap_l2_r == epscp_pkg::STRAP_THREE_WIRE);

  assign unit_len = mode3_link ? epscp_pkg::BITS_3W : epscp_pkg::BITS_4W;
  assign is_last = (bit_cnt_r == unit_len - epscp_pkg::CNT_ONE);

  // bit counter; chip select high holds it clear so frames start aligned
  // a cut frame never reaches its last bit, so nothing is handed on for it
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_r <= epscp_pkg::CNT_ZERO;
    end else if (!link_rst_n_r2) begin
      bit_cnt_r <= epscp_pkg::CNT_ZERO;
    end else if (is_last) begin
      bit_cnt_r <= epscp_pkg::CNT_ZERO;
    end else begin
      bit_cnt_r <= bit_cnt_r + epscp_pkg::CNT_ONE;
    end
  end

  // data shift, msb first; first three-wire bit is the flag
  always_ff @(posedge sclk_i) begin
    if (!cs_n_i) begin
      if (mode3_link && bit_cnt_r == epscp_pkg::CNT_ZERO) begin
        flag_r <= serial_data_in_i;
      end else begin
        shift_r <= {shift_r[6:0], serial_data_in_i};
      end
    end
  end

  // complete byte captured on its own last edge, event signalled by toggle
  always_ff @(posedge sclk_i) begin
    if (!link_rst_n_r2) begin
      byte_tgl_r <= 1'b0;
    end else if (!cs_n_i && is_last) begin
      hold_byte_r <= {shift_r[6:0], serial_data_in_i};
      hold_dc_r <= mode3_link ? flag_r : dc_sel_i;
      byte_tgl_r <= ~byte_tgl_r;
    end
  end

  // ========================================================================
  // system domain
  // ========================================================================
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  logic busy_s1_r;
  logic strap_s1_r;
  logic strap_s2_r;
  epscp_pkg::epscp_stream_type stream_r;
  logic byte_evt;
  logic cmd_evt;
  logic data_evt;
  logic stream_open;

  // a finished unit is a command when its data/command bit is low
  function automatic logic unit_is_cmd(input logic evt, input logic dc);
    return evt && !dc;
  endfunction

  // a finished unit is display data when its data/command bit is high
  function automatic logic unit_is_data(input logic evt, input logic dc);
    return evt && dc;
  endfunction

  // toggle synchroniser; held byte is stable long before the toggle lands
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= byte_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end
  // one event per finished unit, decoded once and shared by all consumers
  assign byte_evt = tgl_s2_r ^ tgl_s3_r;
  assign cmd_evt = unit_is_cmd(byte_evt, hold_dc_r);
  assign data_evt = unit_is_data(byte_evt, hold_dc_r);
  assign stream_open = (stream_r == epscp_pkg::EPSCP_RAM_STREAM);

  // strap through two flops before use
  always_ff @(posedge clk_sys_i) begin
    strap_s1_r <= interface_select_strap_i;
    strap_s2_r <= strap_s1_r;
  end

  // command side: one-cycle strobe, byte holds until the next command
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cmd_byte_o <= epscp_pkg::BYTE_ZERO;
      cmd_valid_o <= 1'b0;
    end else begin
      cmd_valid_o <= cmd_evt;
      if (cmd_evt) begin
        cmd_byte_o <= hold_byte_r;
      end
    end
  end

  // data side: the byte follows every data unit, but the strobe only fires
  // inside an open stream, so stray data never reaches display memory
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ram_byte_o <= epscp_pkg::BYTE_ZERO;
      ram_valid_o <= 1'b0;
    end else begin
      ram_valid_o <= data_evt && stream_open;
      if (data_evt) begin
        ram_byte_o <= hold_byte_r;
      end
    end
  end

  // data-start opens the RAM stream, any other command closes it
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      stream_r <= epscp_pkg::EPSCP_IDLE;
    end else if (cmd_evt) begin
      case (hold_byte_r == epscp_pkg::CMD_DATA_START)
        1'b1: stream_r <= epscp_pkg::EPSCP_RAM_STREAM;
        default: stream_r <= epscp_pkg::EPSCP_IDLE;
      endcase
    end
  end

  // stream status mirrors the state one cycle later, straight from a flop
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ram_stream_o <= 1'b0;
    end else begin
      ram_stream_o <= stream_open;
    end
  end

  // mode status: the strap after its two system flops
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      three_wire_mode_o <= 1'b0;
    end else begin
      three_wire_mode_o <= (strap_s2_r == epscp_pkg::STRAP_THREE_WIRE);
    end
  end

  // busy follows the engine's own level; the port only relays it and does
  // not hold off the host by itself, so the host must watch the pin
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      busy_s1_r <= 1'b0;
      busy_n_o <= 1'b1;
    end else begin
      busy_s1_r <= engine_busy_i;
      busy_n_o <= !busy_s1_r;
    end
  end

  // no read path exists: serial data is input only, nothing is driven back
endmodule // epscp_port

// file: verification/epscp_checker.sv
`timescale 1ns/1ps
// ==========
// port checker
module epscp_checker (
  input logic clk_sys_i,
  input logic resetn_i,
  input logic interface_select_strap_i,
  input logic engine_busy_i,
  input logic [7:0] cmd_byte_o,
  input logic cmd_valid_o,
  input logic ram_valid_o,
  input logic ram_stream_o,
  input logic three_wire_mode_o,
  input logic busy_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // valids are single pulses, one kind at a time
  a_cmd_pulse: assert property (cmd_valid_o |=> !cmd_valid_o) else $error("cmd");
  a_ram_pulse: assert property (ram_valid_o |=> !ram_valid_o) else $error("ram");
  a_one_kind: assert property (!(cmd_valid_o && ram_valid_o)) else $error("kind");
  a_cmd_held: assert property (!$stable(cmd_byte_o) |-> cmd_valid_o) else $error("held");
  // stream opens on the start command and shuts on any other
  a_stream_open: assert property (cmd_valid_o && cmd_byte_o == epscp_pkg::CMD_DATA_START
    |=> ram_stream_o) else $error("open");
  a_stream_shut: assert property (cmd_valid_o && cmd_byte_o != epscp_pkg::CMD_DATA_START
    |=> !ram_stream_o) else $error("shut");
  a_ram_stream: assert property (ram_valid_o |-> ram_stream_o) else $error("stream");
  a_busy_out: assert property (engine_busy_i |-> ##2 !busy_n_o) else $error("busy");
  a_busy_free: assert property (!engine_busy_i |-> ##2 busy_n_o) else $error("free");
  // strap passes three system flops, so four stable cycles settle it
  a_mode_strap: assert property ($stable(interface_select_strap_i)[*4]
    |-> three_wire_mode_o == interface_select_strap_i) else $error("mode");
  c_cmd: cover property (cmd_valid_o);
  c_ram: cover property (ram_valid_o && three_wire_mode_o);
  c_busy: cover property (!busy_n_o);
endmodule // epscp_checker

// file: verification/epscp_host.sv
`timescale 1ns/1ps
// ==========
// host side model, write only
module epscp_host (
  output logic sclk_o,
  output logic sdata_o,
  output logic dc_o,
  output logic cs_n_o
);
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    dc_o = 1'b0;
    cs_n_o = 1'b1;
  end
  // deselected clocks let the link side reset sync clear
  task automatic idle(input int n);
    repeat (n) begin
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
  endtask
  // msb first, data set mid low phase; cut above 0 aborts the unit
  task automatic send(input logic [8:0] u, input int n, input logic dc, input int cut);
    cs_n_o = 1'b0;
    dc_o = dc;
    for (int i = n - 1; i >= cut; i--) begin
      #16 sdata_o = u[i];
      #16 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    sdata_o = ~sdata_o;
    dc_o = ~dc_o;
  endtask
endmodule // epscp_host

// file: verification/epscp_port_tb.sv
`timescale 1ns/1ps
module epscp_port_tb;
  logic clk_sys_i, resetn_i, sclk_i, serial_data_in_i, dc_sel_i, cs_n_i, busy_n_o;
  logic interface_select_strap_i, engine_busy_i, cmd_valid_o, ram_valid_o;
  logic ram_stream_o, three_wire_mode_o;
  logic [7:0] cmd_byte_o, ram_byte_o;
  logic [7:0] n_cmd = 8'h00;
  logic [7:0] n_ram = 8'h00;
  int n_mismatch = 0;
  int num_checks = 0;
  // ==========
  // clock, partner and block
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  epscp_host u_host (.sclk_o(sclk_i), .sdata_o(serial_data_in_i), .dc_o(dc_sel_i),
    .cs_n_o(cs_n_i));
  epscp_port u_dut (.clk_sys_i, .resetn_i, .sclk_i, .serial_data_in_i, .dc_sel_i, .cs_n_i,
    .interface_select_strap_i, .engine_busy_i, .cmd_byte_o, .cmd_valid_o, .ram_byte_o,
    .ram_valid_o, .ram_stream_o, .three_wire_mode_o, .busy_n_o);
  // pulses are counted so none slips between checks
  always @(negedge clk_sys_i) begin
    if (cmd_valid_o === 1'b1) n_cmd <= n_cmd + 8'h01;
    if (ram_valid_o === 1'b1) n_ram <= n_ram + 8'h01;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic unit(input logic [8:0] u, input int n, input logic dc, input int cut);
    u_host.send(u, n, dc, cut);
    repeat (8) @(negedge clk_sys_i);
  endtask
  task automatic t_four;
    unit({1'b0, 8'h10}, 8, 1'b0, 0);
    check(cmd_byte_o, 8'h10);
    unit({1'b0, 8'ha5}, 8, 1'b1, 0);
    unit({1'b0, 8'hff}, 8, 1'b1, 4);
    unit({1'b0, 8'h3c}, 8, 1'b1, 0);
    check(ram_byte_o, 8'h3c);
    unit({1'b0, 8'h12}, 8, 1'b0, 0);
    unit({1'b0, 8'h5a}, 8, 1'b1, 0);
    check(ram_byte_o, 8'h5a);
    check(n_ram, 8'h02);
  endtask
  task automatic t_three;
    interface_select_strap_i = 1'b1;
    u_host.idle(4);
    unit({1'b0, 8'h10}, 9, 1'b1, 0);
    check(cmd_byte_o, 8'h10);
    unit({1'b1, 8'hc3}, 9, 1'b0, 0);
    check(ram_byte_o, 8'hc3);
    check({n_cmd[3:0], n_ram[3:0]}, 8'h33);
  endtask
  task automatic t_busy;
    engine_busy_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check({7'h00, busy_n_o}, 8'h00);
    engine_busy_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    check({7'h00, busy_n_o}, 8'h01);
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // main sequence; the link clock runs during reset
  initial begin
    {resetn_i, interface_select_strap_i, engine_busy_i} = 3'h0;
    fork
      u_host.idle(9);
      repeat (16) @(negedge clk_sys_i);
    join
    resetn_i = 1'b1;
    u_host.idle(3);
    t_four;
    t_three;
    t_busy;
    close_out;
  end
  // whole run is near 8 us
  initial begin
    #100000;
    n_mismatch++;
    close_out;
  end
endmodule // epscp_port_tb
bind epscp_port epscp_checker u_chk (.clk_sys_i, .resetn_i, .interface_select_strap_i,
  .engine_busy_i, .cmd_byte_o, .cmd_valid_o, .ram_valid_o, .ram_stream_o,
  .three_wire_mode_o, .busy_n_o);
